// >>> verilog/wim_top.sv
// wake-edge selection and interrupt masking with its spi register port.
// assumes spi pins synchronous to clk_in, mode 0 (sample on sclk rise,
// shift on fall), sclk at most clk_in/4, and one-cycle event pulses.
`timescale 1ns/1ps
// Contract
// - edge code none, rise, fall, any
// - pin 3 wake field, reset clear
// - pin 4 wake field, reset clear
// - pin 5 wake field, reset clear
// - pair 4/5 inhibit blocks their pulse
// - pair 2/3 inhibit blocks their pulse
// - pair inhibit hides pair from io flag
// - width bit selects 100 or 25 us
// - mask byte layout, global inhibit all
// - sense undervoltage inhibit blocks its pulse
// - pre-regulator inhibit blocks its pulse
// - core inhibit blocks its pulse
// - other-regulator inhibit blocks their pulse
// - reply upper byte carries global flags
module wim_top #(
    parameter int LONG_CYC = wim_pkg::PULSE_LONG_CYC,
    parameter int SHORT_CYC = wim_pkg::PULSE_SHORT_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // spi port
    input wire logic spi_cs_b_in,
    input wire logic spi_sclk_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // general-purpose pins and events
    input wire logic [2:0] pin_level_in,
    input wire logic io2_evt_in,
    input wire logic io01_flag_in,
    input wire logic [3:0] io_active_in,
    // regulator events and global flags
    input wire wim_pkg::wim_reg_evt_t reg_evt_in,
    input wire wim_pkg::wim_gflags_t gflags_in,
    // results
    output logic [2:0] wake_evt_out,
    output logic int_b_out,
    output logic [7:0] wake_edge_cfg_out,
    output logic [7:0] irq_mask_cfg_out
);
    // configuration registers
    logic [7:0] wake_edge_r;
    logic [7:0] irq_mask_r;
    // spi state
    logic sclk_q_r;
    logic cs_q_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] rx_r;
    logic [15:0] reply_r;
    logic miso_r;
    logic oe_r;
    // pin edge state
    logic [2:0] lvl_q_r;
    logic [2:0] wake_r;
    // pulse state
    logic int_act_r;
    logic [wim_pkg::PULSE_CNT_W-1:0] cnt_r;
    // decoded strobes and fields
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic [5:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_ok;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic [2:0] wake_nxt;
    logic [5:0] sel_all;
    logic inh23;
    logic inh45;
    logic io_g;
    logic [7:0] flag_byte;
    logic trig;
    logic [wim_pkg::PULSE_CNT_W-1:0] width_sel;

    assign inh23 = wake_edge_r[wim_pkg::WE_INH23_POS];
    assign inh45 = wake_edge_r[wim_pkg::WE_INH45_POS];
    assign sclk_rise = !spi_cs_b_in && spi_sclk_in && !sclk_q_r;
    assign sclk_fall = !spi_cs_b_in && !spi_sclk_in && sclk_q_r;
    assign cs_fall = !spi_cs_b_in && cs_q_r;
    assign cs_rise = spi_cs_b_in && !cs_q_r;

    assign io_g = io01_flag_in | (|io_active_in[1:0] & !inh23) | (|io_active_in[3:2] & !inh45);

    // global flags, bit 12 reserved zero
    assign flag_byte = {gflags_in.spi_g, gflags_in.wakeup_flag, gflags_in.can_g, 1'b0,
                        io_g, gflags_in.pre_g, gflags_in.core_g, gflags_in.others_g};

    // register read mux, unmapped reads give zero
    assign rd_addr = rx_r[5:0];
    always_comb begin
        if (rd_addr == wim_pkg::ADDR_WAKE_EDGE) begin
            rd_data = wake_edge_r;
        end else if (rd_addr == wim_pkg::ADDR_IRQ_MASK) begin
            rd_data = irq_mask_r;
        end else begin
            rd_data = 8'h00;
        end
    end

    // full frame, write bit, odd parity
    assign wr_ok = cs_rise && (bit_cnt_r == 5'(wim_pkg::FRAME_BITS))
                   && rx_r[wim_pkg::FRM_WR_BIT] && (^rx_r);

    // edge samples of spi pins
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sclk_q_r <= 1'b0;
            cs_q_r <= 1'b1;
        end else begin
            sclk_q_r <= spi_sclk_in;
            cs_q_r <= spi_cs_b_in;
        end
    end

    // receive shifter and bit count
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bit_cnt_r <= 5'h00;
            rx_r <= 16'h0000;
        end else if (cs_fall) begin
            bit_cnt_r <= 5'h00;
        end else if (sclk_rise && bit_cnt_r != 5'(wim_pkg::FRAME_BITS)) begin
            // extra clocks beyond a frame are ignored
            bit_cnt_r <= bit_cnt_r + 5'h01;
            rx_r <= {rx_r[14:0], spi_mosi_in};
        end
    end

    // reply word and miso bit
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reply_r <= 16'h0000;
            miso_r <= 1'b0;
        end else if (cs_fall) begin
            reply_r <= {flag_byte, 8'h00};
            miso_r <= flag_byte[7];
        end else begin
            // lower byte known once the address is in
            if (sclk_rise && bit_cnt_r == 5'h07) begin
                reply_r[7:0] <= rd_data;
            end
            if (sclk_fall && bit_cnt_r < 5'(wim_pkg::FRAME_BITS)) begin
                miso_r <= reply_r[4'(5'h0f - bit_cnt_r)];
            end
        end
    end

    // miso drive enable follows chip select
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= !spi_cs_b_in;
        end
    end

    // wake field register, cleared at reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_edge_r <= wim_pkg::WE_RESET;
        end else if (wr_ok && rx_r[14:9] == wim_pkg::ADDR_WAKE_EDGE) begin
            wake_edge_r <= rx_r[7:0] & wim_pkg::WE_WMASK;
        end
    end

    // mask byte, reserved bits kept zero
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_mask_r <= wim_pkg::IM_RESET;
        end else if (wr_ok && rx_r[14:9] == wim_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= rx_r[7:0] & wim_pkg::IM_WMASK;
        end
    end

    assign sel_all = wake_edge_r[7:2];
    assign pin_rise = pin_level_in & ~lvl_q_r;
    assign pin_fall = ~pin_level_in & lvl_q_r;
    always_comb begin
        wake_nxt = 3'b000;
        for (int i = 0; i < 3; i++) begin
            // pins 3 to 5, sel bit 0 rise, bit 1 fall
            wake_nxt[i] = (sel_all[5-2*i-1] & pin_rise[i]) | (sel_all[5-2*i] & pin_fall[i]);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lvl_q_r <= 3'b000;
            wake_r <= 3'b000;
        end else begin
            lvl_q_r <= pin_level_in;
            wake_r <= wake_nxt;
        end
    end

    assign trig = !irq_mask_r[wim_pkg::IM_ALL_POS] & (
        ((io2_evt_in | wake_r[0]) & !inh23) |
        (|wake_r[2:1] & !inh45) |
        (reg_evt_in.battery_sense_undervolt & !irq_mask_r[wim_pkg::IM_SNS_POS]) |
        (reg_evt_in.pre_chg & !irq_mask_r[wim_pkg::IM_PRE_POS]) |
        (reg_evt_in.core_chg & !irq_mask_r[wim_pkg::IM_CORE_POS]) |
        (|reg_evt_in.others_chg & !irq_mask_r[wim_pkg::IM_OTH_POS]));

    assign width_sel = irq_mask_r[wim_pkg::IM_DUR_POS] ?
                       wim_pkg::PULSE_CNT_W'(SHORT_CYC - 1) :
                       wim_pkg::PULSE_CNT_W'(LONG_CYC - 1);

    // pulse counter, events during a pulse merge into it
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            int_act_r <= 1'b0;
            cnt_r <= '0;
        end else if (!int_act_r) begin
            if (trig) begin
                int_act_r <= 1'b1;
                cnt_r <= width_sel;
            end
        end else if (cnt_r == '0) begin
            int_act_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // outputs
    assign spi_miso_out = miso_r;
    assign spi_miso_oe_out = oe_r;
    assign wake_evt_out = wake_r;
    assign int_b_out = !int_act_r;
    assign wake_edge_cfg_out = wake_edge_r;
    assign irq_mask_cfg_out = irq_mask_r;

    // checks ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // pulse length helper
    logic [wim_pkg::PULSE_CNT_W:0] len_r;
    logic [wim_pkg::PULSE_CNT_W-1:0] want_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            len_r <= '0;
            want_r <= '0;
        end else if (!int_act_r && trig) begin
            len_r <= '0;
            // expected length straight from the width parameters
            want_r <= irq_mask_r[wim_pkg::IM_DUR_POS] ?
                      wim_pkg::PULSE_CNT_W'(SHORT_CYC) :
                      wim_pkg::PULSE_CNT_W'(LONG_CYC);
        end else if (int_act_r) begin
            len_r <= len_r + 1'b1;
        end
    end

    sequence s_start;
        !int_act_r && trig;
    endsequence
    sequence s_high;
        int_act_r [*2];
    endsequence

    property p_rise_only;
        (sel_all[5:4] == wim_pkg::EDGE_RISE) && pin_rise[0] |=> wake_r[0];
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rise not woken");
    property p_no_wake;
        (sel_all[3:2] == wim_pkg::EDGE_NONE) |=> !wake_r[1];
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake with none");
    property p_fall_only;
        (sel_all[1:0] == wim_pkg::EDGE_FALL) && pin_rise[2] |=> !wake_r[2];
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("rise woke pin 5");
    property p_all_inh;
        irq_mask_r[wim_pkg::IM_ALL_POS] && !int_act_r |=> !int_act_r;
    endproperty
    a_all_inh: assert property (p_all_inh) else $error("pulse under inhibit");
    property p_start;
        s_start |=> s_high;
    endproperty
    a_start: assert property (p_start) else $error("pulse not started");
    property p_width;
        $fell(int_act_r) |-> (len_r == {1'b0, want_r});
    endproperty
    a_width: assert property (p_width) else $error("pulse width wrong");
    property p_io_mask;
        inh23 && inh45 && !io01_flag_in |-> !flag_byte[3];
    endproperty
    a_io_mask: assert property (p_io_mask) else $error("masked pair in io flag");
    property p_flag_first;
        cs_fall |=> spi_miso_out == $past(gflags_in.spi_g);
    endproperty
    a_flag_first: assert property (p_flag_first) else $error("first bit not spi flag");
    property p_bad_par;
        cs_rise && !(^rx_r) |=> $stable(wake_edge_r) && $stable(irq_mask_r);
    endproperty
    a_bad_par: assert property (p_bad_par) else $error("bad parity written");
    property p_rsvd;
        irq_mask_r[6] == 1'b0 && irq_mask_r[0] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule : wim_top

// >>> verilog/wim_pkg.sv
// package for the wake-edge and interrupt mask block: frame layout, field
// positions, reset values, pulse timing and the carrier structs.
// assumes a 125 MHz system clock and a 16-bit spi frame, msb first.
package wim_pkg;
    // frame layout: bit 15 write, bits 14:9 address, bit 8 parity, 7:0 data
    localparam int FRAME_BITS = 16;
    localparam int FRM_WR_BIT = 15;
    localparam int FRM_PAR_BIT = 8;
    localparam logic [5:0] ADDR_WAKE_EDGE = 6'h05;
    localparam logic [5:0] ADDR_IRQ_MASK = 6'h06;
    // wake-edge register fields
    localparam int WE_PIN3_POS = 6;
    localparam int WE_PIN4_POS = 4;
    localparam int WE_PIN5_POS = 2;
    localparam int WE_INH23_POS = 1;
    localparam int WE_INH45_POS = 0;
    localparam logic [7:0] WE_RESET = 8'h00;
    localparam logic [7:0] WE_WMASK = 8'hff;
    // interrupt mask register fields
    localparam int IM_DUR_POS = 7;
    localparam int IM_ALL_POS = 5;
    localparam int IM_SNS_POS = 4;
    localparam int IM_PRE_POS = 3;
    localparam int IM_CORE_POS = 2;
    localparam int IM_OTH_POS = 1;
    localparam logic [7:0] IM_RESET = 8'h00;
    localparam logic [7:0] IM_WMASK = 8'hbe;
    // wake edge encodings
    localparam logic [1:0] EDGE_NONE = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_ANY = 2'b11;
    // interrupt pulse timing
    localparam int CLK_MHZ = 125;
    localparam int PULSE_LONG_US = 100;
    localparam int PULSE_SHORT_US = 25;
    localparam int PULSE_LONG_CYC = PULSE_LONG_US * CLK_MHZ;
    localparam int PULSE_SHORT_CYC = PULSE_SHORT_US * CLK_MHZ;
    localparam int PULSE_CNT_W = 14;
    // global status flags supplied by the rest of the chip
    typedef struct packed {
        logic spi_g;
        logic wakeup_flag;
        logic can_g;
        logic pre_g;
        logic core_g;
        logic others_g;
    } wim_gflags_t;
    // regulator interrupt events, one-cycle pulses
    typedef struct packed {
        logic battery_sense_undervolt;
        logic pre_chg;
        logic core_chg;
        logic [2:0] others_chg;
    } wim_reg_evt_t;
endpackage : wim_pkg

// >>> dv/wim_host_model.sv
// host model: spi master for 16-bit frames and a timer for interrupt pulses.
// assumes clk_in is the device clock; pins change only at its falling edge.
`timescale 1ns/1ps
module wim_host_model (
    // clock
    input wire logic clk_in,
    // spi pins
    output logic cs_b_out,
    output logic sclk_out,
    output logic mosi_out,
    input wire logic miso_in,
    // interrupt line
    input wire logic int_b_in
);
    logic [15:0] rep; // last reply word
    logic [15:0] frm; // frame being sent
    int int_len; // low cycles of last pulse
    int cnt = 0; // running low count
    event rep_done; // reply ready
    event int_done; // pulse over
    initial begin
        cs_b_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end
    // one frame, msb first, sclk low four clocks and high two per bit
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
                        input logic bad);
        frm = {wr, a, 1'b0, d};
        frm[8] = ~(^frm) ^ bad;
        @(negedge clk_in);
        cs_b_out = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (2) @(negedge clk_in);
            mosi_out = frm[i];
            repeat (2) @(negedge clk_in);
            sclk_out = 1'b1;
            rep[i] = miso_in;
            repeat (2) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        repeat (2) @(negedge clk_in);
        cs_b_out = 1'b1;
        // released line shows the inverse of its last bit
        mosi_out = ~mosi_out;
        repeat (3) @(negedge clk_in);
        ->rep_done;
    endtask : xfer
    // time each low pulse
    always @(negedge clk_in) begin
        if (int_b_in === 1'b0) begin
            cnt = cnt + 1;
        end else if (cnt != 0) begin
            int_len = cnt;
            cnt = 0;
            ->int_done;
        end
    end
endmodule : wim_host_model

// >>> dv/wim_top_test.sv
// bench for the wake-edge and interrupt mask block with a host model.
// assumes the host model file is compiled first; short pulse counts.
`timescale 1ns/1ps
module wim_top_test;
    localparam int LONG = 20;
    localparam int SHORT = 5;
    logic clk_in, rst_b_in, miso, oe, int_b, io2_evt, io01, cs_b, sclk, mosi;
    logic [2:0] pins, wake;
    logic [3:0] io_act;
    logic [7:0] we_cfg, im_cfg, cur_w, cur_m, w, m;
    wim_pkg::wim_reg_evt_t revt;
    wim_pkg::wim_gflags_t gf;
    logic [15:0] q_rep[$];
    int q_len[$];
    logic [2:0] q_wake[$];
    int miscompares = 0;
    int checked = 0;
    wim_top #(.LONG_CYC(LONG), .SHORT_CYC(SHORT)) i_dut (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .spi_cs_b_in(cs_b), .spi_sclk_in(sclk),
        .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe),
        .pin_level_in(pins), .io2_evt_in(io2_evt), .io01_flag_in(io01),
        .io_active_in(io_act), .reg_evt_in(revt), .gflags_in(gf),
        .wake_evt_out(wake), .int_b_out(int_b), .wake_edge_cfg_out(we_cfg),
        .irq_mask_cfg_out(im_cfg));
    wim_host_model i_host (.clk_in(clk_in), .cs_b_out(cs_b), .sclk_out(sclk),
        .mosi_out(mosi), .miso_in(miso), .int_b_in(int_b));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic miss(input string n, input logic [15:0] e, input logic [15:0] g);
        miscompares++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
    endtask : miss
    task automatic cmp_rep(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) miss(n, e, g);
    endtask : cmp_rep
    task automatic cmp_len(input int e, input int g);
        checked++;
        if (g != e) miss("pulse", 16'(e), 16'(g));
    endtask : cmp_len
    task automatic cmp_wake(input logic [2:0] e, input logic [2:0] g);
        checked++;
        if (g !== e) miss("wake", 16'(e), 16'(g));
    endtask : cmp_wake
    task automatic cmp_oe(input logic e, input logic g);
        checked++;
        if (g !== e) miss("oe", 16'(e), 16'(g));
    endtask : cmp_oe
    // reply expected from flags, masked io activity and the old data
    function automatic logic [15:0] exp_rep(input logic [7:0] d);
        logic io;
        io = io01 | ((|io_act[1:0]) & ~cur_w[1]) | ((|io_act[3:2]) & ~cur_w[0]);
        return {gf[5:3], 1'b0, io, gf[2:0], d};
    endfunction : exp_rep
    // one frame with fresh random flags
    task automatic frame(input logic wr, input logic [5:0] a, input logic [7:0] d,
                         input logic bad);
        logic ok;
        @(negedge clk_in);
        {gf, io_act, io01} = 11'($urandom);
        q_rep.push_back(exp_rep(a == 6'h05 ? cur_w : a == 6'h06 ? cur_m : 8'h00));
        i_host.xfer(wr, a, d, bad);
        ok = wr && !bad;
        if (ok && a == wim_pkg::ADDR_WAKE_EDGE) cur_w = d;
        if (ok && a == wim_pkg::ADDR_IRQ_MASK) cur_m = d & wim_pkg::IM_WMASK;
        cmp_rep("cfg", {cur_w, cur_m}, {we_cfg, im_cfg});
    endtask : frame
    // fire source s: 0..5 regulator events, 6 the pin 2 event
    task automatic fire(input int s);
        logic inh;
        @(negedge clk_in);
        inh = (s == 6) ? cur_w[1] : cur_m[(s < 3) ? 1 : s - 1];
        if (!cur_m[5] && !inh) q_len.push_back(cur_m[7] ? SHORT : LONG);
        if (s < 6) revt = 6'(6'h01 << s);
        else io2_evt = 1'b1;
        @(negedge clk_in);
        revt = '0;
        io2_evt = 1'b0;
        repeat (40) @(negedge clk_in);
    endtask : fire
    // move pin p to level v and note the wake and pulse it must give
    task automatic pin(input int p, input logic v);
        logic [1:0] sel;
        @(negedge clk_in);
        sel = cur_w[7 - 2 * p -: 2];
        // rise uses the low code bit, fall the high one
        if (v ? sel[0] : sel[1]) begin
            q_wake.push_back(3'(3'b001 << p));
            if (!cur_m[5] && !cur_w[p == 0]) q_len.push_back(cur_m[7] ? SHORT : LONG);
        end
        pins[p] = v;
        repeat (40) @(negedge clk_in);
    endtask : pin
    always @(i_host.rep_done) begin
        if (q_rep.size() == 0) miss("reply", 16'h0000, i_host.rep);
        else cmp_rep("reply", q_rep.pop_front(), i_host.rep);
    end
    always @(i_host.int_done) begin
        if (q_len.size() == 0) miss("pulse", 16'h0000, 16'(i_host.int_len));
        else cmp_len(q_len.pop_front(), i_host.int_len);
    end
    always @(negedge clk_in) begin
        if (rst_b_in && wake !== 3'b000) begin
            if (q_wake.size() == 0) miss("wake", 16'h0000, 16'(wake));
            else cmp_wake(q_wake.pop_front(), wake);
        end
    end
    // miso drive enable follows chip select one clock late
    logic cs_seen;
    always @(posedge clk_in) cs_seen <= cs_b;
    always @(negedge clk_in) begin
        if (rst_b_in) cmp_oe(!cs_seen, oe);
    end
    // watchdog on the whole run
    initial begin
        repeat (100000) @(posedge clk_in);
        miscompares++;
        stop_test();
    end
    initial begin
        {rst_b_in, pins, io2_evt, io01, io_act, cur_w, cur_m} = '0;
        revt = '0;
        gf = '0;
        void'($urandom(33));
        repeat (8) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (2) @(negedge clk_in);
        // reset values, unmapped place, bad parity
        frame(1'b0, wim_pkg::ADDR_WAKE_EDGE, 8'h00, 1'b0);
        frame(1'b0, wim_pkg::ADDR_IRQ_MASK, 8'h00, 1'b0);
        frame(1'b1, 6'h07, 8'hff, 1'b0);
        frame(1'b0, 6'h07, 8'h00, 1'b0);
        frame(1'b1, wim_pkg::ADDR_WAKE_EDGE, 8'hff, 1'b1);
        for (int k = 0; k < 8; k++) begin
            // every edge code on every pin, twice over eight passes
            w = {2'(k), 2'(k) ^ 2'b01, 2'(k) ^ 2'b10, 2'($urandom)};
            m = 8'($urandom) & (k < 4 ? 8'hdf : 8'hff);
            frame(1'b1, wim_pkg::ADDR_WAKE_EDGE, w, 1'b0);
            frame(1'b1, wim_pkg::ADDR_IRQ_MASK, m, 1'b0);
            frame(1'b0, wim_pkg::ADDR_IRQ_MASK, 8'h00, 1'b0);
            for (int s = 0; s < 7; s++) fire(s);
            for (int p = 0; p < 3; p++) begin
                pin(p, 1'b1);
                pin(p, 1'b0);
            end
        end
        // second reset clears both registers
        rst_b_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_b_in = 1'b1;
        {cur_w, cur_m} = '0;
        repeat (2) @(negedge clk_in);
        frame(1'b0, wim_pkg::ADDR_WAKE_EDGE, 8'h00, 1'b0);
        frame(1'b0, wim_pkg::ADDR_IRQ_MASK, 8'h00, 1'b0);
        repeat (40) @(negedge clk_in);
        if (q_rep.size() + q_len.size() + q_wake.size() != 0) miss("left", 16'h0, 16'h1);
        stop_test();
    end
endmodule : wim_top_test
